//--- rtl/acq_pkg.sv
// Shared constants for the acquisition control ends
// What this block does
// (R1) Decode 4-bit gain code into range and gain
// (R2) Host waits gain settling before triggering
// (R3) Channel register keeps low four bits only
// (R4) Single-ended: four bits pick one of 16
// (R5) Differential: three bits pick one of 8
// (R6) Host waits multiplexer settling before triggering; a later gain write overwrites the mux wait, even with a shorter gain wait
// (R7) Mode register write-only, three low bits used
// (R8) Internal strap: modes off, soft, pacer DMA/IRQ
// (R9) External strap: modes off, external DMA/IRQ
// (R10) Strap picks internal or external trigger source
// (R11) Pacer tick starts conversions periodically
// (R12) Any soft trigger write starts one conversion
// (R13) Ready flag readable in high result byte
// (R14) Host polls until ready reads zero
// (R15) Host flags missing board on ready timeout
// (R16) Ready one until done; result split bytes
// (R17) Interrupt flag per conversion, cleared by write
// (R18) Two DMA requests per conversion, one per byte
// (R19) Gain register write-only, four low bits
// (R20) Mode resets to 000, everything disabled
// (R21) Triggers during a conversion are ignored
package acq_pkg;
    localparam int CLK_MHZ = 100;
    localparam int RES_W = 12;
    localparam int CNT_W = 18;
    localparam logic [3:0] ADR_RES_LO = 4'h4;
    localparam logic [3:0] ADR_RES_HI = 4'h5;
    localparam logic [3:0] ADR_INT_CLR = 4'h8;
    localparam logic [3:0] ADR_GAIN = 4'h9;
    localparam logic [3:0] ADR_CHAN = 4'ha;
    localparam logic [3:0] ADR_MODE = 4'hb;
    localparam logic [3:0] ADR_SOFT_TRIG = 4'hc;
    localparam int READY_BIT = 4;
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_SOFT_POLL = 3'h1;
    localparam logic [2:0] MODE_PACED_DMA = 3'h2;
    localparam logic [2:0] MODE_PACED_IRQ = 3'h6;
    localparam logic [1:0] DMA_BYTES = 2'h2;
    localparam int GAIN_SETTLE_X1_US = 23;
    localparam int GAIN_SETTLE_X10_US = 28;
    localparam int GAIN_SETTLE_X100_US = 140;
    localparam int GAIN_SETTLE_X1000_US = 1300;
    localparam int MUX_SETTLE_US = 100;
    localparam int PROBE_TIMEOUT_US = 1000;
    localparam int GAIN_SETTLE_X1_CYC = GAIN_SETTLE_X1_US * CLK_MHZ;
    localparam int GAIN_SETTLE_X10_CYC = GAIN_SETTLE_X10_US * CLK_MHZ;
    localparam logic [7:0] HREG_CMD = 8'h00;
    localparam logic [7:0] HREG_STAT = 8'h04;
    localparam logic [7:0] HREG_DMA = 8'h08;
    localparam logic [7:0] HREG_CTL = 8'h0c;
    localparam int CMD_DATA_LSB = 4;
    localparam int CMD_WRITE_BIT = 12;
    localparam int STAT_BUSY = 0;
    localparam int STAT_IRQ = 1;
    localparam int STAT_DRQ = 2;
    localparam int STAT_NOBOARD = 3;
    localparam int STAT_RDATA_LSB = 8;
    localparam int DMA_VALID_BIT = 16;
    localparam int CTL_DMA_EN = 0;
    localparam int CTL_NOBOARD_CLR = 1;
endpackage

//--- rtl/acq_bus_if.sv
// Card I/O bus joining the host end and the card end
`timescale 1ns/1ps
interface acq_bus_if;
    logic [3:0] io_addr;
    logic [7:0] io_wdata;
    logic io_wr;
    logic io_rd;
    logic [7:0] io_rdata;
    logic io_irq;
    logic io_drq;
    logic io_dack;
    modport dev (
        input io_addr,
        input io_wdata,
        input io_wr,
        input io_rd,
        input io_dack,
        output io_rdata,
        output io_irq,
        output io_drq
    );
    modport host (
        output io_addr,
        output io_wdata,
        output io_wr,
        output io_rd,
        output io_dack,
        input io_rdata,
        input io_irq,
        input io_drq
    );
endinterface

//--- rtl/gain_decode.sv
// Gain code decoder driving the front-end amplifier
`timescale 1ns/1ps
module gain_decode
    import acq_pkg::*;
(
    input wire logic [3:0] code,
    output logic signed_range,
    output logic unsigned_range,
    output logic [1:0] gain_decade,
    output logic half_scale,
    output logic code_valid
);
    // Codes 1100..1111 select nothing; both range lines drop
    wire fam_bip = code[3:2] == 2'b00;
    wire fam_uni = code[3:2] == 2'b01;
    wire fam_half = code[3:2] == 2'b10;

    assign code_valid = fam_bip | fam_uni | fam_half; // see (R1)
    assign signed_range = fam_bip | fam_half; // see (R1)
    assign unsigned_range = fam_uni; // see (R1)
    assign half_scale = fam_half; // see (R1)
    assign gain_decade = code_valid ? code[1:0] : 2'b00; // see (R1)
endmodule

//--- rtl/acq_device.sv
// Card end: registers, trigger selection, ready flag, IRQ and DMA
`timescale 1ns/1ps
module acq_device
    import acq_pkg::*;
#(
    parameter int SEL_W = 4
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    acq_bus_if.dev bus,
    input wire logic trigger_source_strap,
    input wire logic diff_input_strap,
    input wire logic pacer_tick,
    input wire logic ext_trigger,
    input wire logic conv_done,
    input wire logic [RES_W-1:0] conv_data,
    output logic conv_start,
    output logic [SEL_W-1:0] mux_sel,
    output logic amp_code_bit3,
    output logic amp_code_bit2,
    output logic amp_code_bit1,
    output logic amp_code_bit0,
    output logic signed_range,
    output logic unsigned_range,
    output logic [1:0] gain_decade,
    output logic half_scale,
    output logic gain_code_valid,
    output logic conv_busy
);
    if (SEL_W != 4 || RES_W != 12) begin : g_chk
        $error("acq_device supports 4 select bits and 12 result bits");
    end

    logic [2:0] mode_ff;
    logic [2:0] nxt_mode;
    logic [3:0] gain_ff;
    logic [3:0] nxt_gain;
    logic [SEL_W-1:0] chan_ff;
    logic [SEL_W-1:0] nxt_chan;
    logic ext_prev_ff;
    logic busy_ff;
    logic nxt_busy;
    logic ready_n_ff;
    logic nxt_ready_n;
    logic start_ff;
    logic [RES_W-1:0] result_ff;
    logic [RES_W-1:0] nxt_result;
    logic int_flag_ff;
    logic nxt_int_flag;
    logic [1:0] dma_pend_ff;
    logic [1:0] nxt_dma_pend;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    // Register write decode
    wire wr_mode = bus.io_wr && bus.io_addr == ADR_MODE;
    wire wr_gain = bus.io_wr && bus.io_addr == ADR_GAIN;
    wire wr_chan = bus.io_wr && bus.io_addr == ADR_CHAN;
    wire wr_soft = bus.io_wr && bus.io_addr == ADR_SOFT_TRIG;
    wire wr_int_clr = bus.io_wr && bus.io_addr == ADR_INT_CLR;
    wire rd_plain = bus.io_rd && !bus.io_dack;
    wire rd_dma = bus.io_rd && bus.io_dack;

    // Mode decode; strap high means external trigger source
    wire strap_int = !trigger_source_strap; // see (R10)
    wire mode_paced = mode_ff == MODE_PACED_DMA
        || mode_ff == MODE_PACED_IRQ;
    wire soft_en = strap_int && mode_ff == MODE_SOFT_POLL; // see (R8)
    wire pacer_en = strap_int && mode_paced; // see (R8)
    wire ext_en = trigger_source_strap && mode_paced; // see (R9)
    // Transfer paths: 010 is DMA, 110 is interrupt, either strap
    wire dma_en = mode_ff == MODE_PACED_DMA; // see (R8) see (R9)
    wire irq_en = mode_ff == MODE_PACED_IRQ; // see (R8) see (R9)

    // External trigger acts on its rising edge only
    wire ext_rise = ext_trigger && !ext_prev_ff;

    // Any data value counts on the soft trigger write
    wire soft_fire = wr_soft && soft_en; // see (R12)
    wire pacer_fire = pacer_tick && pacer_en; // see (R11)
    wire ext_fire = ext_rise && ext_en; // see (R10)
    wire trig_req = soft_fire || pacer_fire || ext_fire;
    // A trigger inside a running conversion is dropped, so the
    // result and the flag always describe one whole conversion
    wire trig_go = trig_req && !busy_ff; // see (R21)
    // A stray done pulse while idle must not disturb the result
    wire done = conv_done && busy_ff;

    // Next values of the control registers
    assign nxt_mode = wr_mode ? bus.io_wdata[2:0] : mode_ff; // see (R7)
    assign nxt_gain = wr_gain ? bus.io_wdata[3:0] : gain_ff; // see (R19)
    assign nxt_chan = wr_chan ? bus.io_wdata[SEL_W-1:0] : chan_ff; // see (R3)

    assign nxt_busy = trig_go ? 1'b1 : (done ? 1'b0 : busy_ff);
    assign nxt_ready_n = trig_go ? 1'b1
        : (done ? 1'b0 : ready_n_ff); // see (R16)
    assign nxt_result = done ? conv_data : result_ff; // see (R16)

    // A new conversion end wins over a clear in the same cycle;
    // while the flag stays set no second interrupt is raised
    assign nxt_int_flag = (done && irq_en) ? 1'b1
        : (wr_int_clr ? 1'b0 : int_flag_ff); // see (R17)

    // Two requests per result; each acknowledged read takes one
    wire dma_live = dma_pend_ff != 2'b00;
    wire dma_low = dma_pend_ff == DMA_BYTES;
    assign nxt_dma_pend = (done && dma_en) ? DMA_BYTES
        : ((rd_dma && dma_live) ? dma_pend_ff - 2'b01
        : dma_pend_ff); // see (R18)

    // Read data: DMA reads send low byte first, then high byte
    wire [7:0] byte_lo = result_ff[7:0];
    wire [7:0] byte_hi = {3'h0, ready_n_ff,
        result_ff[RES_W-1:8]}; // see (R13) see (R16)
    wire [7:0] plain_data = bus.io_addr == ADR_RES_LO ? byte_lo
        : (bus.io_addr == ADR_RES_HI ? byte_hi : 8'h00);
    wire [7:0] dma_data = dma_low ? byte_lo : byte_hi; // see (R18)
    assign nxt_rdata = rd_dma ? dma_data
        : (rd_plain ? plain_data : rdata_ff);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_ff <= MODE_OFF; // see (R20)
            gain_ff <= 4'h0;
            chan_ff <= '0;
        end else if (ce) begin
            mode_ff <= nxt_mode;
            gain_ff <= nxt_gain;
            chan_ff <= nxt_chan;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_prev_ff <= 1'b0;
            busy_ff <= 1'b0;
            ready_n_ff <= 1'b1;
            start_ff <= 1'b0;
        end else if (ce) begin
            ext_prev_ff <= ext_trigger;
            busy_ff <= nxt_busy;
            ready_n_ff <= nxt_ready_n;
            start_ff <= trig_go;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_ff <= '0;
            int_flag_ff <= 1'b0;
            dma_pend_ff <= 2'b00;
            rdata_ff <= 8'h00;
        end else if (ce) begin
            result_ff <= nxt_result;
            int_flag_ff <= nxt_int_flag;
            dma_pend_ff <= nxt_dma_pend;
            rdata_ff <= nxt_rdata;
        end
    end

    // Differential pairs ignore the top select bit
    assign mux_sel = diff_input_strap
        ? {1'b0, chan_ff[SEL_W-2:0]} // see (R5)
        : chan_ff; // see (R4)

    gain_decode u_gain (
        .code(gain_ff),
        .signed_range(signed_range),
        .unsigned_range(unsigned_range),
        .gain_decade(gain_decade),
        .half_scale(half_scale),
        .code_valid(gain_code_valid)
    );

    assign amp_code_bit3 = gain_ff[3];
    assign amp_code_bit2 = gain_ff[2];
    assign amp_code_bit1 = gain_ff[1];
    assign amp_code_bit0 = gain_ff[0];
    assign conv_start = start_ff;
    assign conv_busy = busy_ff;
    assign bus.io_rdata = rdata_ff;
    assign bus.io_irq = int_flag_ff; // see (R17)
    assign bus.io_drq = dma_live; // see (R18)
endmodule

//--- rtl/acq_host.sv
// Host end: AHB-Lite command registers driving the card I/O bus
`timescale 1ns/1ps
module acq_host
    import acq_pkg::*;
#(
    parameter int unsigned SETTLE_X100_CYC = GAIN_SETTLE_X100_US * CLK_MHZ,
    parameter int unsigned SETTLE_X1000_CYC = GAIN_SETTLE_X1000_US * CLK_MHZ,
    parameter int unsigned MUX_SETTLE_CYC = MUX_SETTLE_US * CLK_MHZ,
    parameter int unsigned PROBE_CYC = PROBE_TIMEOUT_US * CLK_MHZ
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    acq_bus_if.host bus
);
    localparam int unsigned CNT_LIM = 2 ** CNT_W;
    if (SETTLE_X1000_CYC >= CNT_LIM || MUX_SETTLE_CYC >= CNT_LIM
        || PROBE_CYC >= CNT_LIM || SETTLE_X100_CYC == 0) begin : g_chk
        $error("acq_host wait counts do not fit the counters");
    end

    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_IO = 5'b00010,
        S_CAP = 5'b00100,
        S_DMA = 5'b01000,
        S_DCAP = 5'b10000
    } io_state_e;

    io_state_e st_ff;
    io_state_e nxt_st;
    logic dp_wr_ff, dp_hit_ff, cmd_pend_ff, cmd_wr_ff, dma_en_ff;
    logic [7:0] dp_addr_ff, rd_byte_ff, dma_lo_ff;
    logic [3:0] cmd_addr_ff;
    logic [7:0] cmd_data_ff;
    logic [31:0] hrdata_ff;
    logic [RES_W-1:0] dma_word_ff;
    logic dma_valid_ff, dma_hi_ff, probe_on_ff, noboard_ff;
    logic [CNT_W-1:0] settle_ff, probe_ff, nxt_settle, gain_wait;

    // AHB-Lite: zero wait states, always OKAY
    wire ap_go = hsel && htrans[1] && hready;
    wire wr_cmd = dp_wr_ff && dp_hit_ff && dp_addr_ff == HREG_CMD;
    wire wr_ctl = dp_wr_ff && dp_hit_ff && dp_addr_ff == HREG_CTL;
    wire rd_dma_reg = ap_go && !hwrite && haddr[31:8] == 24'h0
        && haddr[7:0] == HREG_DMA;
    wire busy = cmd_pend_ff || st_ff != S_IDLE;

    wire [31:0] stat_word = {16'h0, rd_byte_ff, 4'h0, noboard_ff,
        bus.io_drq, bus.io_irq, busy};
    wire [31:0] rd_mux = haddr[31:8] != 24'h0 ? 32'h0
        : haddr[7:0] == HREG_STAT ? stat_word
        : haddr[7:0] == HREG_DMA ? {15'h0, dma_valid_ff, 4'h0,
            dma_word_ff}
        : haddr[7:0] == HREG_CTL ? {31'h0, dma_en_ff} : 32'h0;

    // A trigger write is held back until the settle count ends; a gain write overwrites any mux wait still left
    wire trig_cmd = cmd_wr_ff && cmd_addr_ff == ADR_SOFT_TRIG;
    wire may_issue = !trig_cmd || settle_ff == '0; // see (R2) see (R6)
    wire io_done = st_ff == S_IO;
    wire set_gain = io_done && cmd_wr_ff && cmd_addr_ff == ADR_GAIN;
    wire set_chan = io_done && cmd_wr_ff && cmd_addr_ff == ADR_CHAN;
    wire mux_wait_big = settle_ff < CNT_W'(MUX_SETTLE_CYC);

    always_comb begin
        unique case (cmd_data_ff[1:0])
            2'b00: gain_wait = CNT_W'(GAIN_SETTLE_X1_CYC);
            2'b01: gain_wait = CNT_W'(GAIN_SETTLE_X10_CYC);
            2'b10: gain_wait = CNT_W'(SETTLE_X100_CYC);
            2'b11: gain_wait = CNT_W'(SETTLE_X1000_CYC);
        endcase
    end
    assign nxt_settle = set_gain ? gain_wait // see (R2)
        : (set_chan && mux_wait_big) ? CNT_W'(MUX_SETTLE_CYC) // see (R6)
        : (settle_ff != '0) ? settle_ff - 1'b1 : settle_ff;

    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            S_IDLE: begin
                if (dma_en_ff && bus.io_drq) begin
                    nxt_st = S_DMA;
                end else if (cmd_pend_ff && may_issue) begin
                    nxt_st = S_IO;
                end
            end
            S_IO: nxt_st = cmd_wr_ff ? S_IDLE : S_CAP;
            S_CAP: nxt_st = S_IDLE;
            S_DMA: nxt_st = S_DCAP;
            S_DCAP: nxt_st = S_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_ff <= 1'b0;
            dp_hit_ff <= 1'b0;
            dp_addr_ff <= 8'h00;
            hrdata_ff <= 32'h0;
        end else if (ce) begin
            dp_wr_ff <= ap_go && hwrite;
            dp_hit_ff <= haddr[31:8] == 24'h0;
            dp_addr_ff <= haddr[7:0];
            hrdata_ff <= (ap_go && !hwrite) ? rd_mux : hrdata_ff;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= S_IDLE;
            cmd_pend_ff <= 1'b0;
            cmd_wr_ff <= 1'b0;
            cmd_addr_ff <= 4'h0;
            cmd_data_ff <= 8'h00;
            dma_en_ff <= 1'b0;
            settle_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
            if (wr_cmd && !busy) begin
                cmd_pend_ff <= 1'b1;
                cmd_addr_ff <= hwdata[3:0];
                cmd_data_ff <= hwdata[CMD_DATA_LSB +: 8];
                cmd_wr_ff <= hwdata[CMD_WRITE_BIT];
            end else if (nxt_st == S_IO) begin
                cmd_pend_ff <= 1'b0;
            end
            dma_en_ff <= wr_ctl ? hwdata[CTL_DMA_EN] : dma_en_ff;
            settle_ff <= nxt_settle;
        end
    end

    // Status byte from the card: ready bit low means data valid
    wire ready_seen = st_ff == S_CAP && cmd_addr_ff == ADR_RES_HI
        && !bus.io_rdata[READY_BIT]; // see (R14)
    wire trig_out = io_done && trig_cmd;
    wire probe_expire = probe_on_ff && probe_ff == '0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_byte_ff <= 8'h00;
            probe_on_ff <= 1'b0;
            probe_ff <= '0;
            noboard_ff <= 1'b0;
        end else if (ce) begin
            rd_byte_ff <= st_ff == S_CAP ? bus.io_rdata : rd_byte_ff;
            probe_on_ff <= trig_out
                || (probe_on_ff && !ready_seen && !probe_expire);
            probe_ff <= trig_out ? CNT_W'(PROBE_CYC)
                : (probe_ff != '0 ? probe_ff - 1'b1 : probe_ff);
            noboard_ff <= probe_expire
                || (noboard_ff && !(wr_ctl
                && hwdata[CTL_NOBOARD_CLR])); // see (R15)
        end
    end

    // DMA bytes arrive low then high; a new word beats a read clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dma_lo_ff <= 8'h00;
            dma_hi_ff <= 1'b0;
            dma_word_ff <= '0;
            dma_valid_ff <= 1'b0;
        end else if (ce) begin
            if (st_ff == S_DCAP) begin
                dma_hi_ff <= !dma_hi_ff;
                dma_lo_ff <= dma_hi_ff ? dma_lo_ff : bus.io_rdata;
                dma_word_ff <= dma_hi_ff
                    ? {bus.io_rdata[3:0], dma_lo_ff} : dma_word_ff;
            end
            dma_valid_ff <= (st_ff == S_DCAP && dma_hi_ff)
                || (dma_valid_ff && !rd_dma_reg);
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    assign bus.io_addr = cmd_addr_ff;
    assign bus.io_wdata = cmd_data_ff;
    assign bus.io_wr = io_done && cmd_wr_ff;
    assign bus.io_rd = (io_done && !cmd_wr_ff) || st_ff == S_DMA;
    assign bus.io_dack = st_ff == S_DMA;
endmodule

//--- sim/acq_chk.sv
// Checker on the card bus between the host end and the card end
`timescale 1ns/1ps
module acq_chk
    import acq_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [3:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_rdata,
    input wire logic io_irq,
    input wire logic io_drq,
    input wire logic io_dack
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [2:0] mode_ff;
    logic [1:0] dack_cnt_ff;
    wire clr_wr = io_wr && io_addr == ADR_INT_CLR;
    wire mode_wr = io_wr && io_addr == ADR_MODE;
    // Mode is write-only, so the checker keeps its own shadow copy
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_ff <= MODE_OFF;
            dack_cnt_ff <= 2'h0;
        end else begin
            if (mode_wr) mode_ff <= io_wdata[2:0];
            if (!io_drq) dack_cnt_ff <= 2'h0;
            else if (io_dack) dack_cnt_ff <= dack_cnt_ff + 2'h1;
        end
    end
    a_strobe_excl: assert property (!(io_wr && io_rd))
        else $error("write and read strobes overlap");
    a_wr_single: assert property (io_wr |=> !io_wr)
        else $error("write strobe longer than one cycle");
    a_rd_single: assert property (io_rd |=> !io_rd)
        else $error("read strobe longer than one cycle");
    a_dack_read: assert property (io_dack |-> io_rd)
        else $error("dma acknowledge without read");
    a_rdata_hold: assert property (!io_rd |=> $stable(io_rdata))
        else $error("read data moved without a read");
    a_irq_hold: assert property (io_irq && !clr_wr |=> io_irq)
        else $error("interrupt dropped without clear write");
    a_irq_mode: assert property (
        $rose(io_irq) |-> mode_ff == MODE_PACED_IRQ)
        else $error("interrupt raised outside mode 110");
    a_drq_mode: assert property (
        $rose(io_drq) |-> mode_ff == MODE_PACED_DMA)
        else $error("dma request outside mode 010");
    a_drq_pair: assert property (
        $fell(io_drq) |-> dack_cnt_ff == DMA_BYTES)
        else $error("dma request ended without two reads");
    c_dma_read: cover property (io_dack);
    c_irq_set: cover property ($rose(io_irq));
    c_ready_poll: cover property (io_rd && io_addr == ADR_RES_HI);
endmodule

//--- sim/test_adc_acquisition_control.sv
// Testbench joining host and card ends through the card bus
`timescale 1ns/1ps
module test_adc_acquisition_control import acq_pkg::*;;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, conv_start, conv_busy, sr, ur, half, gvalid;
    logic [31:0] hrdata, q;
    logic src_strap = 1'b0;
    logic diff_strap = 1'b0;
    logic pacer = 1'b0;
    logic ext_trig = 1'b0;
    logic ce = 1'b1;
    logic conv_done = 1'b0;
    logic [RES_W-1:0] conv_data = 12'ha5c;
    logic [3:0] mux_sel, amp;
    logic [1:0] decade;
    int n_fail = 0;
    int comparisons = 0;
    int n_starts = 0;
    int cv_cnt = 0;
    acq_bus_if bus ();
    always #5 hclk = ~hclk;
    // Gain x100 and x1000, mux settle and probe counts shortened to keep the run brief; x1 and x10 keep their defaults
    acq_host #(.SETTLE_X100_CYC(20), .SETTLE_X1000_CYC(40),
        .MUX_SETTLE_CYC(10), .PROBE_CYC(400)) acq_host_i (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .bus(bus.host));
    acq_device acq_device_i (.hclk(hclk), .hresetn(hresetn), .ce(ce),
        .bus(bus.dev), .trigger_source_strap(src_strap),
        .diff_input_strap(diff_strap), .pacer_tick(pacer),
        .ext_trigger(ext_trig), .conv_done(conv_done),
        .conv_data(conv_data), .conv_start(conv_start), .mux_sel(mux_sel),
        .amp_code_bit3(amp[3]), .amp_code_bit2(amp[2]),
        .amp_code_bit1(amp[1]), .amp_code_bit0(amp[0]),
        .signed_range(sr), .unsigned_range(ur), .gain_decade(decade),
        .half_scale(half), .gain_code_valid(gvalid),
        .conv_busy(conv_busy));
    acq_chk acq_chk_i (.hclk(hclk), .hresetn(hresetn),
        .io_addr(bus.io_addr), .io_wdata(bus.io_wdata), .io_wr(bus.io_wr),
        .io_rd(bus.io_rd), .io_rdata(bus.io_rdata), .io_irq(bus.io_irq),
        .io_drq(bus.io_drq), .io_dack(bus.io_dack));
    // Converter stand-in: long enough that a second trigger lands mid-way
    always @(posedge hclk) begin
        conv_done <= 1'b0;
        if (conv_start === 1'b1) begin
            n_starts++;
            cv_cnt <= 60;
        end else if (cv_cnt > 0) begin
            cv_cnt <= cv_cnt - 1;
            if (cv_cnt == 1) begin
                conv_done <= 1'b1;
                conv_data <= conv_data + 12'h123;
            end
        end
    end
    task automatic check(input string name, input logic [31:0] seen,
            input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wait_bit(input logic [7:0] a, input int b,
            input logic v);
        int i;
        i = 0;
        do begin
            ahb(1'b0, a, 32'h0, q);
            i++;
        end while (q[b] !== v && i < 4000);
        check("poll", q[b], v);
    endtask
    // Host refuses commands while busy, so every card access waits first
    task automatic card_op(input logic w, input logic [3:0] a,
            input logic [7:0] d, output logic [7:0] r);
        wait_bit(HREG_STAT, STAT_BUSY, 1'b0);
        ahb(1'b1, HREG_CMD, {19'h0, w, d, a}, q);
        wait_bit(HREG_STAT, STAT_BUSY, 1'b0);
        r = q[15:8];
    endtask
    task automatic tick();
        pacer <= 1'b1;
        @(posedge hclk);
        pacer <= 1'b0;
    endtask
    task automatic give_verdict();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        give_verdict();
    end
    initial begin
        logic [7:0] b;
        logic [3:0] c;
        int n;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, HREG_STAT, 32'h0, q);
        check("host status", q[3:0], 4'h0);
        card_op(1'b0, ADR_RES_HI, 8'h0, b);
        check("ready at reset", b, 8'h10);
        card_op(1'b1, ADR_SOFT_TRIG, 8'h00, b);
        wait_bit(HREG_STAT, STAT_NOBOARD, 1'b1);
        check("mode off", n_starts, 0);
        check("probe fail", q[STAT_NOBOARD], 1'b1);
        ahb(1'b1, HREG_CTL, 32'h2, q);
        ahb(1'b0, HREG_STAT, 32'h0, q);
        check("probe clear", q[STAT_NOBOARD], 1'b0);
        for (int i = 0; i < 16; i++) begin
            c = 4'(i);
            card_op(1'b1, ADR_GAIN, {4'hf, c}, b);
            check("gain bits", amp, c);
            check("range", {gvalid, sr, ur}, {c[3:2] != 2'h3,
                c[3:2] != 2'h1 && c[3:2] != 2'h3, c[3:2] == 2'h1});
            if (c[3:2] != 2'h3) begin
                check("gain", {half, decade}, {c[3], c[1:0]});
            end
        end
        card_op(1'b1, ADR_CHAN, 8'hfb, b);
        check("single channel", mux_sel, 4'hb);
        diff_strap <= 1'b1;
        card_op(1'b1, ADR_CHAN, 8'hfe, b);
        check("diff channel", mux_sel, 4'h6);
        card_op(1'b1, ADR_MODE, 8'hf9, b);
        card_op(1'b1, ADR_SOFT_TRIG, 8'h5a, b);
        card_op(1'b1, ADR_SOFT_TRIG, 8'ha5, b);
        n = 0;
        do begin
            card_op(1'b0, ADR_RES_HI, 8'h0, b);
            n++;
        end while (b[READY_BIT] !== 1'b0 && n < 200);
        check("one start", n_starts, 1);
        check("idle busy", conv_busy, 1'b0);
        check("high byte", b, {4'h0, conv_data[11:8]});
        card_op(1'b0, ADR_RES_LO, 8'h0, b);
        check("low byte", b, conv_data[7:0]);
        card_op(1'b1, ADR_MODE, 8'hfe, b);
        tick();
        wait_bit(HREG_STAT, STAT_IRQ, 1'b1);
        check("pacer start", n_starts, 2);
        ext_trig <= 1'b1;
        card_op(1'b0, ADR_RES_LO, 8'h0, b);
        check("pacer data", b, conv_data[7:0]);
        check("ext ignored", n_starts, 2);
        card_op(1'b1, ADR_INT_CLR, 8'h3c, b);
        check("irq cleared", bus.io_irq, 1'b0);
        ext_trig <= 1'b0;
        card_op(1'b1, ADR_MODE, 8'hfa, b);
        ahb(1'b1, HREG_CTL, 32'h1, q);
        tick();
        wait_bit(HREG_DMA, DMA_VALID_BIT, 1'b1);
        check("dma word", q[11:0], conv_data);
        ahb(1'b0, HREG_DMA, 32'h0, q);
        check("dma taken", q[DMA_VALID_BIT], 1'b0);
        // Clock enable dropped only while both ends idle, so no strobe
        // is stretched; a pacer tick then must start nothing
        ce <= 1'b0;
        tick();
        ce <= 1'b1;
        repeat (3) @(posedge hclk);
        check("frozen", n_starts, 3);
        src_strap <= 1'b1;
        tick();
        ext_trig <= 1'b1;
        wait_bit(HREG_DMA, DMA_VALID_BIT, 1'b1);
        check("ext start", n_starts, 4);
        check("ext word", q[11:0], conv_data);
        card_op(1'b1, ADR_MODE, 8'hf9, b);
        card_op(1'b1, ADR_SOFT_TRIG, 8'h11, b);
        repeat (4) @(posedge hclk);
        check("ext soft off", n_starts, 4);
        give_verdict();
    end
endmodule
